/* design/fpcc_pkg.sv */
package fpcc_pkg;
	// ****************************************************************
	// Port counts and widths
	// ****************************************************************
	localparam int unsigned NUM_INIT   = 3;   // Two processor buses, I/O
	localparam int unsigned NUM_MEM    = 2;   // Even and odd line ports
	localparam int unsigned ADDR_W     = 33;  // 8 GB of byte addresses
	localparam int unsigned DATA_W     = 64;
	localparam int unsigned CODE_W     = 72;  // Data plus eight check bits
	localparam int unsigned CHK_W      = 7;
	localparam int unsigned SRC_W      = 2;
	localparam int unsigned BRG_W      = 2;   // Up to four I/O bridges
	localparam int unsigned LINE_OFF   = 5;   // Line offset bits
	localparam int unsigned POOL_N     = 64;  // Shared line buffers
	localparam int unsigned POOL_IW    = 6;
	localparam int unsigned FLT_IW     = 4;
	localparam int unsigned FLT_N      = 16;
	localparam int unsigned TAG_W      = ADDR_W - LINE_OFF - FLT_IW;
	localparam int unsigned POOL_ROOM  = 4;   // Free lines to allow returns
	localparam int unsigned POOL_CNT_W = 7;

	// ****************************************************************
	// Initiator indices
	// ****************************************************************
	localparam logic [1:0] SRC_CPU0 = 2'h0;
	localparam logic [1:0] SRC_CPU1 = 2'h1;
	localparam logic [1:0] SRC_IO   = 2'h2;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int unsigned CLK_MHZ  = 200;
	localparam int unsigned BUS_MHZ  = 100;
	localparam int unsigned BUS_DIV  = CLK_MHZ / BUS_MHZ;
	localparam logic [1:0]  DIV_LAST = 2'(BUS_DIV - 1);

	// ****************************************************************
	// Coherency filter line state
	// ****************************************************************
	typedef enum logic [1:0] {
		FLT_INV,
		FLT_SHR,
		FLT_MOD
	} fpcc_fstate_t;
endpackage : fpcc_pkg

/* design/fpcc_top.sv */
// Summary of operation
// - Five ports: two processor, two memory, one I/O
// - Reads proceed while other bus writes complete
// - Nine direct paths among buses and memory
// - Addresses and control pass only address/control chip
// - Each command crosses only one of two chips
// - Address/control chip runs filters, tracks buffered lines
// - Decodes up to eight gigabytes of memory
// - All data crosses buffer chip, five ports concurrently
// - 64 shared line buffers, no dedicated queues
// - Buffered data protected by correcting code
// - Each port 64 bits at 100 MHz
// - Memory ports share one interleaved address range
// - Even lines one port, odd lines other
// - Equal access and latency to both memories
// - Processor filter records its bus's cached lines
// - Filter records shared and current state
// - Snoop other bus only when state requires
// - I/O filter tracks up to four bridges
// - I/O master read checks bridge buffers first
// - Processor and I/O buses 64 bits, 100 MHz
`timescale 1ns/1ps
module fpcc_top (
	input  wire logic                                   i_clk,
	input  wire logic                                   i_rst_n,
	input  wire logic [2:0]                             i_rq_valid,
	input  wire logic [2:0]                             i_rq_write,
	input  wire logic [2:0][fpcc_pkg::ADDR_W-1:0]       i_rq_addr,
	input  wire logic [2:0][fpcc_pkg::DATA_W-1:0]       i_rq_wdata,
	input  wire logic [fpcc_pkg::BRG_W-1:0]             i_io_bridge,
	output logic [2:0]                                  o_rq_ready,
	output logic [2:0]                                  o_snp_valid,
	output logic [2:0]                                  o_snp_inval,
	output logic [2:0][fpcc_pkg::ADDR_W-1:0]            o_snp_addr,
	output logic [1:0]                                  o_mem_valid,
	output logic [1:0]                                  o_mem_write,
	output logic [1:0][fpcc_pkg::ADDR_W-1:0]            o_mem_addr,
	output logic [1:0][fpcc_pkg::CODE_W-1:0]            o_mem_wcode,
	output logic [1:0][fpcc_pkg::SRC_W-1:0]             o_mem_src,
	input  wire logic [1:0]                             i_mem_ready,
	input  wire logic [1:0]                             i_mem_rvalid,
	input  wire logic [1:0][fpcc_pkg::CODE_W-1:0]       i_mem_rcode,
	input  wire logic [1:0][fpcc_pkg::SRC_W-1:0]        i_mem_rsrc,
	output logic [1:0]                                  o_mem_rready,
	output logic [2:0]                                  o_rsp_valid,
	output logic [2:0][fpcc_pkg::DATA_W-1:0]            o_rsp_data,
	output logic [2:0]                                  o_rsp_err,
	input  wire logic [2:0]                             i_rsp_ready,
	output logic                                        o_bus_tick
);
	// ****************************************************************
	// Functions
	// ****************************************************************
	function automatic logic [71:0] ecc_enc(input logic [63:0] d);
		logic [71:0] cw;
		int          j;
		cw = '0;
		j = 0;
		for (int p = 1; p < 72; p++) begin
			if ((p & (p - 1)) != 0) begin
				cw[p] = d[j];
				j++;
			end
		end
		for (int k = 0; k < 7; k++) begin
			for (int p = 1; p < 72; p++) begin
				if (((p >> k) & 1) == 1 && p != (1 << k)) begin
					cw[1 << k] = cw[1 << k] ^ cw[p];
				end
			end
		end
		cw[0] = ^cw[71:1];
		return cw;
	endfunction : ecc_enc

	// Returns {uncorrectable, data}; single flips are repaired
	function automatic logic [64:0] ecc_dec(input logic [71:0] c);
		logic [71:0] cw;
		logic [6:0]  s;
		logic [63:0] d;
		logic        unc;
		int          j;
		cw = c;
		s = '0;
		d = '0;
		unc = 1'b0;
		j = 0;
		for (int k = 0; k < 7; k++) begin
			for (int p = 1; p < 72; p++) begin
				if (((p >> k) & 1) == 1) begin
					s[k] = s[k] ^ cw[p];
				end
			end
		end
		if (s != 7'h00) begin
			if ((^cw) && (s < 7'h48)) begin
				cw[s] = ~cw[s];
			end else begin
				unc = 1'b1;
			end
		end
		for (int p = 1; p < 72; p++) begin
			if ((p & (p - 1)) != 0) begin
				d[j] = cw[p];
				j++;
			end
		end
		return {unc, d};
	endfunction : ecc_dec

	function automatic logic [5:0] first_one(input logic [63:0] m);
		logic [5:0] r;
		r = '0;
		for (int k = 63; k >= 0; k--) begin
			if (m[k]) begin
				r = 6'(k);
			end
		end
		return r;
	endfunction : first_one

	function automatic logic [6:0] pop_cnt(input logic [63:0] m);
		logic [6:0] r;
		r = '0;
		for (int k = 0; k < 64; k++) begin
			r = r + {6'h00, m[k]};
		end
		return r;
	endfunction : pop_cnt

	// ****************************************************************
	// Bus rate enable
	// ****************************************************************
	logic [1:0] div_reg;
	logic       tick_reg;
	logic       pre_tick;
	logic [1:0] last_reg;

	assign pre_tick   = (div_reg == fpcc_pkg::DIV_LAST);
	assign o_bus_tick = tick_reg;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			div_reg  <= 2'h0;
			tick_reg <= 1'b0;
		end else begin
			div_reg  <= pre_tick ? 2'h0 : div_reg + 2'h1;
			tick_reg <= pre_tick;
		end
	end

	// ****************************************************************
	// Address/control chip: request grant
	// ****************************************************************
	logic [1:0]  h_v;
	logic [1:0]  t_v;
	logic [2:0]  take;
	logic        take_any;
	logic [1:0]  tk_idx;
	logic        tk_wr;
	logic [32:0] tk_a;
	logic [63:0] tk_d;
	logic        tk_sel;
	logic [2:0]  rr_pick;

	// Round robin after last winner keeps both processor buses equal
	always_comb begin
		rr_pick = 3'h0;
		for (int n = 3; n >= 1; n--) begin
			if (i_rq_valid[(int'(last_reg) + n) % 3]) begin
				rr_pick = 3'h0;
				rr_pick[(int'(last_reg) + n) % 3] = 1'b1;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rq_ready <= 3'h0;
			last_reg   <= fpcc_pkg::SRC_IO;
		end else if (pre_tick && t_v == 2'h0) begin
			o_rq_ready <= rr_pick;
		end else begin
			o_rq_ready <= 3'h0;
			if (take_any) begin
				last_reg <= tk_idx;
			end
		end
	end

	// Selected command; one per bus tick keeps filters single-ported
	always_comb begin
		take     = i_rq_valid & o_rq_ready & {3{tick_reg}};
		take_any = |take;
		tk_idx   = take[1] ? fpcc_pkg::SRC_CPU1 :
			(take[2] ? fpcc_pkg::SRC_IO : fpcc_pkg::SRC_CPU0);
		tk_wr    = i_rq_write[tk_idx];
		tk_a     = i_rq_addr[tk_idx];
		tk_d     = i_rq_wdata[tk_idx];
		tk_sel   = tk_a[fpcc_pkg::LINE_OFF];
	end

	// ****************************************************************
	// Address/control chip: coherency filters
	// ****************************************************************
	fpcc_pkg::fpcc_fstate_t       cf_st  [2][16];
	logic [fpcc_pkg::TAG_W-1:0]   cf_tag [2][16];
	logic [fpcc_pkg::TAG_W-1:0]   io_tag [16];
	logic [1:0]                   io_br  [16];
	logic [15:0]                  io_v;
	logic [3:0]                   ix;
	logic [fpcc_pkg::TAG_W-1:0]   tg;
	logic [1:0]                   cf_hit;
	logic                         io_hit;
	logic [2:0]                   snp_need;
	logic [2:0]                   snp_inv;

	assign ix = tk_a[fpcc_pkg::LINE_OFF +: fpcc_pkg::FLT_IW];
	assign tg = tk_a[fpcc_pkg::ADDR_W-1 -: fpcc_pkg::TAG_W];

	always_comb begin
		snp_need = 3'h0;
		snp_inv  = {3{tk_wr}};
		for (int b = 0; b < 2; b++) begin
			cf_hit[b] = cf_st[b][ix] != fpcc_pkg::FLT_INV &&
				cf_tag[b][ix] == tg;
			if (int'(tk_idx) != b && cf_hit[b] &&
				(tk_wr || cf_st[b][ix] == fpcc_pkg::FLT_MOD)) begin
				snp_need[b] = take_any;
			end
		end
		io_hit = io_v[ix] && io_tag[ix] == tg;
		if (io_hit && (tk_wr || (tk_idx == fpcc_pkg::SRC_IO &&
			io_br[ix] != i_io_bridge))) begin
			snp_need[2] = take_any;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			for (int b = 0; b < 2; b++) begin
				for (int e = 0; e < 16; e++) begin
					cf_st[b][e]  <= fpcc_pkg::FLT_INV;
					cf_tag[b][e] <= '0;
				end
			end
		end else if (take_any) begin
			for (int b = 0; b < 2; b++) begin
				if (int'(tk_idx) == b) begin
					cf_tag[b][ix] <= tg;
					cf_st[b][ix]  <= tk_wr ? fpcc_pkg::FLT_MOD :
						fpcc_pkg::FLT_SHR;
				end else if (cf_hit[b] && tk_wr) begin
					cf_st[b][ix] <= fpcc_pkg::FLT_INV;
				end else if (cf_hit[b]) begin
					cf_st[b][ix] <= fpcc_pkg::FLT_SHR;
				end
			end
		end
	end

	// bridge-owned lines on the I/O bus
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			io_v <= 16'h0000;
			for (int e = 0; e < 16; e++) begin
				io_tag[e] <= '0;
				io_br[e]  <= 2'h0;
			end
		end else if (take_any && tk_idx == fpcc_pkg::SRC_IO) begin
			io_v[ix]   <= !tk_wr;
			io_tag[ix] <= tg;
			io_br[ix]  <= i_io_bridge;
		end else if (take_any && io_hit && tk_wr) begin
			io_v[ix] <= 1'b0;
		end
	end

	// snoop addresses leave from this side
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_snp_valid <= 3'h0;
			o_snp_inval <= 3'h0;
			o_snp_addr  <= '0;
		end else begin
			o_snp_valid <= snp_need;
			o_snp_inval <= snp_inv;
			if (take_any) begin
				o_snp_addr <= {3{tk_a}};
			end
		end
	end

	// ****************************************************************
	// Data buffer chip: memory port two-entry queues
	// ****************************************************************
	logic [1:0]              t_w;
	logic [1:0][32:0]        t_a;
	logic [1:0][71:0]        t_c;
	logic [1:0][1:0]         t_s;
	logic [71:0]             tk_code;

	assign tk_code     = ecc_enc(tk_d);
	assign o_mem_valid = h_v;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			h_v <= 2'h0;
			t_v <= 2'h0;
			t_w <= 2'h0;
			t_a <= '0;
			t_c <= '0;
			t_s <= '0;
			o_mem_write <= 2'h0;
			o_mem_addr  <= '0;
			o_mem_wcode <= '0;
			o_mem_src   <= '0;
		end else if (tick_reg) begin
			for (int m = 0; m < 2; m++) begin
				if (h_v[m] && i_mem_ready[m]) begin
					if (t_v[m]) begin
						o_mem_write[m] <= t_w[m];
						o_mem_addr[m]  <= t_a[m];
						o_mem_wcode[m] <= t_c[m];
						o_mem_src[m]   <= t_s[m];
						t_v[m]         <= take_any && int'(tk_sel) == m;
					end else begin
						h_v[m] <= take_any && int'(tk_sel) == m;
					end
					if (take_any && int'(tk_sel) == m && t_v[m]) begin
						t_w[m] <= tk_wr;
						t_a[m] <= tk_a;
						t_c[m] <= tk_code;
						t_s[m] <= tk_idx;
					end else if (take_any && int'(tk_sel) == m) begin
						o_mem_write[m] <= tk_wr;
						o_mem_addr[m]  <= tk_a;
						o_mem_wcode[m] <= tk_code;
						o_mem_src[m]   <= tk_idx;
					end
				end else if (take_any && int'(tk_sel) == m) begin
					if (!h_v[m]) begin
						h_v[m]         <= 1'b1;
						o_mem_write[m] <= tk_wr;
						o_mem_addr[m]  <= tk_a;
						o_mem_wcode[m] <= tk_code;
						o_mem_src[m]   <= tk_idx;
					end else begin
						t_v[m] <= 1'b1;
						t_w[m] <= tk_wr;
						t_a[m] <= tk_a;
						t_c[m] <= tk_code;
						t_s[m] <= tk_idx;
					end
				end
			end
		end
	end

	// ****************************************************************
	// Data buffer chip: shared line pool
	// ****************************************************************
	logic [71:0]  pool_code [64];
	logic [1:0]   pool_own  [64];
	logic [63:0]  pool_v;
	logic [1:0]   alloc;
	logic [5:0]   f0;
	logic [5:0]   f1;
	logic [2:0]   pick;
	logic [2:0][5:0] pick_ix;
	logic [63:0]  own_m [3];

	// Any free line takes any return; no per-bus queues
	always_comb begin
		alloc = i_mem_rvalid & o_mem_rready & {2{tick_reg}};
		f0    = first_one(~pool_v);
		f1    = first_one(~pool_v & ~(64'h1 << f0));
		for (int i = 0; i < 3; i++) begin
			for (int e = 0; e < 64; e++) begin
				own_m[i][e] = pool_v[e] && int'(pool_own[e]) == i;
			end
			pick_ix[i] = first_one(own_m[i]);
			pick[i]    = tick_reg && (|own_m[i]) &&
				(!o_rsp_valid[i] || i_rsp_ready[i]);
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pool_v <= 64'h0;
			for (int e = 0; e < 64; e++) begin
				pool_code[e] <= '0;
				pool_own[e]  <= 2'h0;
			end
		end else begin
			for (int i = 0; i < 3; i++) begin
				if (pick[i]) begin
					pool_v[pick_ix[i]] <= 1'b0;
				end
			end
			if (alloc[0]) begin
				pool_v[f0]    <= 1'b1;
				pool_code[f0] <= i_mem_rcode[0];
				pool_own[f0]  <= i_mem_rsrc[0];
			end
			if (alloc[1]) begin
				pool_v[alloc[0] ? f1 : f0]    <= 1'b1;
				pool_code[alloc[0] ? f1 : f0] <= i_mem_rcode[1];
				pool_own[alloc[0] ? f1 : f0]  <= i_mem_rsrc[1];
			end
		end
	end

	// Margin of four lines covers the one-cycle flag lag
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_mem_rready <= 2'h0;
		end else begin
			o_mem_rready <= {2{pop_cnt(~pool_v) >=
				7'(fpcc_pkg::POOL_ROOM)}};
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rsp_valid <= 3'h0;
			o_rsp_data  <= '0;
			o_rsp_err   <= 3'h0;
		end else begin
			for (int i = 0; i < 3; i++) begin
				if (pick[i]) begin
					o_rsp_valid[i] <= 1'b1;
					{o_rsp_err[i], o_rsp_data[i]} <=
						ecc_dec(pool_code[pick_ix[i]]);
				end else if (tick_reg && i_rsp_ready[i]) begin
					o_rsp_valid[i] <= 1'b0;
				end
			end
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	chk_tick_rate: assert property (
		o_bus_tick |=> !o_bus_tick ##1 o_bus_tick)
		else $error("bus tick not every second cycle");
	chk_grant_onehot: assert property (
		o_rq_ready != 3'h0 |-> $onehot(o_rq_ready) && o_bus_tick)
		else $error("grant not single or off tick");
	chk_even_port: assert property (
		o_mem_valid[0] |-> !o_mem_addr[0][5])
		else $error("odd line on even port");
	chk_odd_port: assert property (
		o_mem_valid[1] |-> o_mem_addr[1][5])
		else $error("even line on odd port");
	chk_take_to_port: assert property (
		take_any && !tk_sel |=> o_mem_valid[0])
		else $error("taken command missing at port");
	chk_head_hold: assert property (
		o_mem_valid[1] && !i_mem_ready[1] |=>
		o_mem_valid[1] && $stable(o_mem_wcode[1]))
		else $error("stalled memory word changed");
	chk_snoop_cause: assert property (
		o_snp_valid[0] |-> $past(take_any) && $past(tk_idx) != 2'h0)
		else $error("snoop without cause");
	chk_snoop_pulse: assert property (
		o_snp_valid[1] |=> !o_snp_valid[1])
		else $error("snoop longer than one cycle");
	chk_ecc_round: assert property (
		o_mem_valid[0] |->
		ecc_dec(o_mem_wcode[0] ^ 72'h2000) == ecc_dec(o_mem_wcode[0]))
		else $error("single flip not corrected");
	chk_pool_room: assert property (
		o_mem_rready[0] |-> pop_cnt(~pool_v) >= 7'h02)
		else $error("returns accepted without room");

	cov_snoop: cover property (take_any ##1 o_snp_valid != 3'h0);
	cov_both_ports: cover property (o_mem_valid == 2'h3);
	cov_queue_full: cover property (t_v[0] && !i_mem_ready[0]);
	cov_response: cover property (o_rsp_valid[2] && i_rsp_ready[2]);
endmodule : fpcc_top

/* testbench/fpcc_mem_model.sv */
`timescale 1ns/1ps
// ****************************************************************
// Even and odd memory arrays behind the two line ports
// ****************************************************************
module fpcc_mem_model (
	input  wire logic                             i_clk,
	input  wire logic                             i_rst_n,
	input  wire logic                             i_tick,
	input  wire logic [1:0]                       i_valid,
	input  wire logic [1:0]                       i_write,
	input  wire logic [1:0][fpcc_pkg::ADDR_W-1:0] i_addr,
	input  wire logic [1:0][fpcc_pkg::CODE_W-1:0] i_wcode,
	input  wire logic [1:0][fpcc_pkg::SRC_W-1:0]  i_src,
	input  wire logic [1:0]                       i_rready,
	input  wire logic [1:0]                       i_stall,
	input  wire logic [fpcc_pkg::CODE_W-1:0]      i_flip,
	output logic [1:0]                            o_ready,
	output logic [1:0]                            o_rvalid,
	output logic [1:0][fpcc_pkg::CODE_W-1:0]      o_rcode,
	output logic [1:0][fpcc_pkg::SRC_W-1:0]       o_rsrc
);
	logic [fpcc_pkg::CODE_W-1:0] cells [logic [fpcc_pkg::ADDR_W:0]];
	logic [fpcc_pkg::CODE_W+1:0] ret_q [2][$];
	logic [fpcc_pkg::ADDR_W:0]   key;

	// tick-paced transfers
	// Codes are stored as sent; the flip mask lets the bench corrupt reads
	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_ready = 2'h0;
			o_rvalid = 2'h0;
			o_rcode = '0;
			o_rsrc = '0;
			ret_q[0].delete();
			ret_q[1].delete();
		end else begin
			for (int p = 0; p < 2; p++) begin
				key = {p[0], i_addr[p]};
				if (i_tick && o_rvalid[p] && i_rready[p]) begin
					void'(ret_q[p].pop_front());
				end
				if (i_tick && i_valid[p] && o_ready[p]) begin
					if (i_write[p]) begin
						cells[key] = i_wcode[p];
					end else begin
						ret_q[p].push_back({i_src[p], i_flip ^
							(cells.exists(key) ? cells[key] : '0)});
					end
				end
			end
			#1;
			// Idle return lines toggle so a stale word never looks valid
			for (int p = 0; p < 2; p++) begin
				o_ready[p] = !i_stall[p];
				o_rvalid[p] = (ret_q[p].size() != 0);
				if (o_rvalid[p]) begin
					{o_rsrc[p], o_rcode[p]} = ret_q[p][0];
				end else begin
					o_rsrc[p] = ~o_rsrc[p];
					o_rcode[p] = ~o_rcode[p];
				end
			end
		end
	end
endmodule : fpcc_mem_model

/* testbench/fpcc_top_test.sv */
`timescale 1ns/1ps
`define CHK(nm, x, g) begin cmp_count++; if ((g) !== (x)) begin \
	failures++; $display("Error %s expected %h seen %h", nm, x, g); end end
// ****************************************************************
// Crossbar bench
// ****************************************************************
module fpcc_top_test;
	localparam int unsigned AW = fpcc_pkg::ADDR_W;
	localparam int unsigned DW = fpcc_pkg::DATA_W;
	localparam int unsigned CW = fpcc_pkg::CODE_W;
	localparam logic [AW-1:0] ADR [3] = '{33'h0_0000_1000, 33'h0_0000_1020,
		33'h1_ffff_ffe0};
	logic                 clk, rst_n, tick, run, tick_prev, last_port;
	logic [2:0]           rq_valid, rq_write, rq_ready, rsp_ready;
	logic [2:0]           rsp_valid, rsp_err, snp_valid, snp_inval;
	logic [2:0]           snp_seen, snp_inv;
	logic [2:0][AW-1:0]   rq_addr, snp_addr;
	logic [2:0][DW-1:0]   rq_wdata, rsp_data;
	logic [1:0]           brg, mem_valid, mem_write, mem_ready;
	logic [1:0]           mem_rvalid, mem_rready, stall, last_src;
	logic [1:0][AW-1:0]   mem_addr;
	logic [1:0][CW-1:0]   mem_wcode, mem_rcode;
	logic [1:0][1:0]      mem_src, mem_rsrc;
	logic [CW-1:0]        flip;
	logic [AW-1:0]        last_addr, snp_a;
	int                   failures, cmp_count, cyc;

	fpcc_top u_fpcc_top (.i_clk(clk), .i_rst_n(rst_n), .i_rq_valid(rq_valid),
		.i_rq_write(rq_write), .i_rq_addr(rq_addr), .i_rq_wdata(rq_wdata),
		.i_io_bridge(brg), .o_rq_ready(rq_ready), .o_snp_valid(snp_valid),
		.o_snp_inval(snp_inval), .o_snp_addr(snp_addr),
		.o_mem_valid(mem_valid), .o_mem_write(mem_write),
		.o_mem_addr(mem_addr), .o_mem_wcode(mem_wcode), .o_mem_src(mem_src),
		.i_mem_ready(mem_ready), .i_mem_rvalid(mem_rvalid),
		.i_mem_rcode(mem_rcode), .i_mem_rsrc(mem_rsrc),
		.o_mem_rready(mem_rready), .o_rsp_valid(rsp_valid),
		.o_rsp_data(rsp_data), .o_rsp_err(rsp_err), .i_rsp_ready(rsp_ready),
		.o_bus_tick(tick));

	fpcc_mem_model u_fpcc_mem_model (.i_clk(clk), .i_rst_n(rst_n),
		.i_tick(tick), .i_valid(mem_valid), .i_write(mem_write),
		.i_addr(mem_addr), .i_wcode(mem_wcode), .i_src(mem_src),
		.i_rready(mem_rready), .i_stall(stall), .i_flip(flip),
		.o_ready(mem_ready), .o_rvalid(mem_rvalid), .o_rcode(mem_rcode),
		.o_rsrc(mem_rsrc));

	// Clock at 200 MHz
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	always @(posedge clk) begin
		if (run) `CHK("tick", ~tick_prev, tick)
		tick_prev = tick;
		if (rst_n && snp_valid != 3'h0) begin
			snp_seen = snp_seen | snp_valid;
			snp_inv = snp_inv | (snp_valid & snp_inval);
			snp_a = snp_addr[0];
		end
		for (int p = 0; p < 2; p++) begin
			if (rst_n && tick && mem_valid[p] && mem_ready[p]) begin
				last_port = p[0];
				last_addr = mem_addr[p];
				last_src = mem_src[p];
			end
		end
	end

	// Hang guard, well above the planned run
	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			failures++;
			report_and_stop();
		end
	end

	function automatic logic [DW-1:0] pat(input logic [AW-1:0] a);
		return 64'hc0de_0000_0000_0000 ^ DW'(a);
	endfunction : pat

	// Request held until granted on a tick edge
	task automatic req(input int i, input logic w, input logic [AW-1:0] a,
		input logic [DW-1:0] d, output int n);
		n = 0;
		// Let an edge pass so a back-to-back call never re-raises valid
		@(posedge clk);
		#1;
		rq_valid[i] = 1'b1;
		rq_write[i] = w;
		rq_addr[i] = a;
		rq_wdata[i] = d;
		do begin
			@(posedge clk);
			n++;
		end while (!(tick && rq_ready[i]) && n < 400);
		#1 rq_valid[i] = 1'b0;
		`CHK("grant", 1'b1, n < 400)
	endtask : req

	task automatic rsp(input int i, output logic [DW-1:0] d, output logic e);
		int n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (!(tick && rsp_valid[i] && rsp_ready[i]) && n < 400);
		d = rsp_data[i];
		e = rsp_err[i];
		#1;
		`CHK("rsp_seen", 1'b1, n < 400)
	endtask : rsp

	task automatic wr(input int i, input logic [AW-1:0] a,
		input logic [DW-1:0] d);
		int n;
		req(i, 1'b1, a, d, n);
	endtask : wr

	task automatic rd(input int i, input logic [AW-1:0] a,
		input logic [DW-1:0] x, input logic xe);
		int n;
		logic [DW-1:0] d;
		logic e;
		req(i, 1'b0, a, 64'h0, n);
		rsp(i, d, e);
		`CHK("rsp_err", xe, e)
		if (!xe) `CHK("rsp_data", x, d)
	endtask : rd

	task automatic snp_chk(input logic [2:0] xv, input logic [2:0] xi);
		repeat (3) @(posedge clk);
		#1;
		`CHK("snoop", xv, snp_seen)
		`CHK("snoop_inval", xi, snp_inv)
		snp_seen = 3'h0;
		snp_inv = 3'h0;
	endtask : snp_chk

	task automatic s_basic();
		for (int i = 0; i < 3; i++) begin
			wr(i, ADR[i], pat(ADR[i]));
			repeat (4) @(posedge clk);
			#1;
			`CHK("port", ADR[i][5], last_port)
			`CHK("addr", ADR[i], last_addr)
			`CHK("src", 2'(i), last_src)
		end
		for (int i = 0; i < 3; i++) begin
			rd(i, ADR[(i + 1) % 3], pat(ADR[(i + 1) % 3]), 1'b0);
		end
		// Reads of lines modified on a processor bus snoop that bus; the I/O write leaves no filter entry
		snp_chk(3'h3, 3'h0);
	endtask : s_basic

	task automatic s_snoop();
		snp_chk(3'h0, 3'h0);
		wr(0, 33'h2000, 64'h5a5a);
		snp_chk(3'h0, 3'h0);
		rd(1, 33'h2000, 64'h5a5a, 1'b0);
		`CHK("snoop_addr", 33'h2000, snp_a)
		snp_chk(3'h1, 3'h0);
		rd(1, 33'h2000, 64'h5a5a, 1'b0);
		snp_chk(3'h0, 3'h0);
		wr(1, 33'h2000, 64'h7);
		snp_chk(3'h1, 3'h1);
	endtask : s_snoop

	task automatic s_io();
		brg = 2'h1;
		rd(2, 33'h3000, 64'h0, 1'b0);
		snp_chk(3'h0, 3'h0);
		brg = 2'h3;
		rd(2, 33'h3000, 64'h0, 1'b0);
		snp_chk(3'h4, 3'h0);
		wr(0, 33'h3000, 64'h9);
		snp_chk(3'h4, 3'h4);
	endtask : s_io

	task automatic s_stall();
		int n;
		stall[0] = 1'b1;
		fork
			begin
				repeat (30) @(posedge clk);
				#1 stall[0] = 1'b0;
			end
		join_none
		wr(0, 33'h5000, pat(33'h5000));
		wr(1, 33'h5040, pat(33'h5040));
		req(2, 1'b1, 33'h5080, pat(33'h5080), n);
		`CHK("refused", 1'b1, n > 15)
		for (int k = 0; k < 3; k++) begin
			rd(k, 33'h5000 + 33'(k * 64), pat(33'h5000 + 33'(k * 64)), 1'b0);
		end
		`CHK("mem_idle", 2'h0, mem_valid)
	endtask : s_stall

	task automatic s_ecc();
		wr(0, 33'h4020, 64'h1234_5678_9abc_def0);
		flip = 72'h2000;
		rd(0, 33'h4020, 64'h1234_5678_9abc_def0, 1'b0);
		flip = 72'h2100;
		rd(0, 33'h4020, 64'h0, 1'b1);
		flip = '0;
	endtask : s_ecc

	task automatic s_hold();
		int n;
		logic [DW-1:0] d;
		logic e;
		rsp_ready[1] = 1'b0;
		req(1, 1'b0, 33'h4020, 64'h0, n);
		repeat (20) @(posedge clk);
		#1;
		`CHK("rsp_hold", 1'b1, rsp_valid[1])
		`CHK("rsp_hdata", 64'h1234_5678_9abc_def0, rsp_data[1])
		rsp_ready[1] = 1'b1;
		rsp(1, d, e);
		`CHK("rsp_data", 64'h1234_5678_9abc_def0, d)
		repeat (3) @(posedge clk);
		#1;
		`CHK("rsp_drop", 1'b0, rsp_valid[1])
	endtask : s_hold

	task automatic s_conc();
		fork
			wr(0, 33'h6000, 64'h600d);
			rd(1, ADR[0], pat(ADR[0]), 1'b0);
			rd(2, ADR[1], pat(ADR[1]), 1'b0);
		join
		rd(2, 33'h6000, 64'h600d, 1'b0);
	endtask : s_conc

	task automatic report_and_stop();
		$display("Checks %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : report_and_stop

	// Main sequence
	initial begin
		rst_n = 1'b0;
		run = 1'b0;
		rq_valid = 3'h0;
		rq_write = 3'h0;
		rq_addr = '0;
		rq_wdata = '0;
		brg = 2'h0;
		rsp_ready = 3'h7;
		stall = 2'h0;
		flip = '0;
		snp_seen = 3'h0;
		snp_inv = 3'h0;
		repeat (20) @(posedge clk);
		#1;
		`CHK("reset_out", 9'h0, {rq_ready, mem_valid, rsp_valid, tick})
		rst_n = 1'b1;
		repeat (4) @(posedge clk);
		#1 run = 1'b1;
		s_basic();
		s_snoop();
		s_io();
		s_stall();
		s_ecc();
		s_hold();
		s_conc();
		report_and_stop();
	end
endmodule : fpcc_top_test
